// ### qsf_pkg.sv
// Register map, field layout and pulse types of the quad serial flash configuration block
package qsf_pkg;

    localparam logic [3:0]  CFG_OFFSET      = 4'h0;
    localparam logic [3:0]  BDCTRL_OFFSET   = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h8;

    localparam int          CHIP_SELECT_OUTPUT_ENABLES_LSB        = 24;
    localparam int          MODEN_BIT       = 23;
    localparam int          DATA_LINE_OUTPUT_ENABLE_LSB      = 20;
    localparam int          CTLRST_BIT      = 19;
    localparam int          RXRST_BIT       = 18;
    localparam int          TXRST_BIT       = 17;
    localparam int          SWRST_BIT       = 16;
    localparam int          BURST_BIT       = 12;
    localparam int          HOLD_BIT        = 10;
    localparam int          WP_BIT          = 9;
    localparam int          START_BIT       = 2;
    localparam int          POLL_BIT        = 1;
    localparam int          DMA_BIT         = 0;

    // Stored (non self-clearing) bits of the configuration word; reserved 14:13 and unimplemented read zero
    localparam logic [31:0] CFG_RW_MASK     = 32'h03B0_163F;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    localparam logic [31:0] BDCTRL_RW_MASK  = 32'h0000_0007;
    localparam logic [31:0] BDCTRL_RESET    = 32'h0000_0000;

    localparam logic [1:0]  DATA_LINE_OUTPUT_ENABLE_QUAD     = 2'b10;
    localparam logic [1:0]  DATA_LINE_OUTPUT_ENABLE_DUAL     = 2'b01;
    localparam logic [1:0]  DATA_LINE_OUTPUT_ENABLE_SINGLE   = 2'b00;

    // Length of every reset pulse, in CLK cycles
    localparam logic [1:0]  PULSE_CYCLES    = 2'h2;

    typedef struct packed {
        logic control_queue_reset;
        logic receive_queue_reset;
        logic transmit_queue_reset;
        logic module_reset;
    } reset_pulses_t;

    typedef struct packed {
        logic descriptor_start;
        logic descriptor_poll_enable;
        logic direct_memory_access_enable;
    } descriptor_ctrl_t;

endpackage

// ### qsf_config.sv
// Configuration, reset pulse and descriptor control block of a quad serial flash controller
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/10ps

module qsf_config
    import qsf_pkg::*;
(
    // Clock and reset
    input  wire  logic                       CLK,
    input  wire  logic                       RESET,
    // Wishbone slave
    input  wire  logic                       CYC_I,
    input  wire  logic                       STB_I,
    input  wire  logic                       WE_I,
    input  wire  logic [3:0]                 ADR_I,
    input  wire  logic [3:0]                 SEL_I,
    input  wire  logic [31:0]                DAT_I,
    output logic       [31:0]                DAT_O,
    output logic                             ACK_O,
    output logic                             ERR_O,
    // Link status
    input  wire  logic                       LINK_CLK,
    output logic                             LINK_ACTIVE,
    // Chip selects and data line enables
    output logic       [1:0]                 CHIP_SELECT_OE,
    output logic       [3:0]                 DATA_LINE_OE,
    output logic                             HOLD_OUT,
    output logic                             WP_OUT,
    output logic                             BURST_ENABLE,
    // Controls toward the queues and processor
    output qsf_pkg::reset_pulses_t           RESET_PULSES,
    output qsf_pkg::descriptor_ctrl_t        DESCRIPTOR_CTRL
);
    import qsf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                                input logic [31:0] new_value,
                                                input logic [3:0]  lanes);
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++)
        begin
            if (lanes[i])
            begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus and registers

    logic [31:0]  cfg;
    logic [31:0]  bdctrl;
    logic [3:0]   pend;
    logic [1:0]   pulse_count;
    logic         ack;
    logic         err;
    logic [31:0]  rdata;
    logic [31:0]  next_cfg;
    logic [31:0]  next_bdctrl;
    logic [3:0]   next_pend;
    logic [1:0]   next_pulse_count;
    logic         next_ack;
    logic         next_err;
    logic [31:0]  next_rdata;
    logic         link_active;

    logic         request;
    logic         hit;
    logic [31:0]  merged;
    logic         soft_reset;

    assign request    = CYC_I && STB_I && !ack && !err;
    assign soft_reset = pend[0] && (pulse_count != 2'h0);

    always_comb
    begin
        next_cfg         = cfg;
        next_bdctrl      = bdctrl;
        next_pend        = pend;
        next_pulse_count = pulse_count;
        next_ack         = 1'b0;
        next_err         = 1'b0;
        next_rdata       = rdata;
        hit              = (ADR_I == CFG_OFFSET) || (ADR_I == BDCTRL_OFFSET) || (ADR_I == STATUS_OFFSET);
        merged           = 32'h0000_0000;

        // Pulses count down, then the request bits drop back to zero
        if (pulse_count != 2'h0)
        begin
            next_pulse_count = pulse_count - 2'h1;
            if (pulse_count == 2'h1)
            begin
                next_pend = 4'h0;
            end
        end

        if (soft_reset)
        begin
            next_bdctrl = BDCTRL_RESET;
        end

        if (request)
        begin
            next_ack = hit;
            next_err = !hit;
            if (WE_I && ADR_I == CFG_OFFSET)
            begin
                merged   = merge_bytes(cfg, DAT_I, SEL_I);
                next_cfg = merged & CFG_RW_MASK;
                if (SEL_I[2] && (DAT_I[CTLRST_BIT] || DAT_I[RXRST_BIT]
                                 || DAT_I[TXRST_BIT] || DAT_I[SWRST_BIT]))
                begin
                    next_pend = pend | {DAT_I[CTLRST_BIT], DAT_I[RXRST_BIT],
                                        DAT_I[TXRST_BIT], DAT_I[SWRST_BIT]};
                    next_pulse_count = PULSE_CYCLES;
                end
            end
            else if (WE_I && ADR_I == BDCTRL_OFFSET)
            begin
                next_bdctrl = merge_bytes(bdctrl, DAT_I, SEL_I) & BDCTRL_RW_MASK;
            end
            if (!WE_I)
            begin
                case (ADR_I)
                    CFG_OFFSET:
                    begin
                        next_rdata = cfg | ({28'h000_0000, pend} << SWRST_BIT);
                    end
                    BDCTRL_OFFSET:
                    begin
                        next_rdata = bdctrl;
                    end
                    STATUS_OFFSET:
                    begin
                        next_rdata = {31'h0000_0000, link_active};
                    end
                    default:
                    begin
                        next_rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            cfg         <= CFG_RESET;
            bdctrl      <= BDCTRL_RESET;
            pend        <= 4'h0;
            pulse_count <= 2'h0;
            ack         <= 1'b0;
            err         <= 1'b0;
            rdata       <= 32'h0000_0000;
        end
        else
        begin
            cfg         <= next_cfg;
            bdctrl      <= next_bdctrl;
            pend        <= next_pend;
            pulse_count <= next_pulse_count;
            ack         <= next_ack;
            err         <= next_err;
            rdata       <= next_rdata;
        end
    end

    assign ACK_O = ack;
    assign ERR_O = err;
    assign DAT_O = rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Link clock watch; three stages, a change counts once stages two and three agree

    logic [2:0]   link_sync;
    logic [2:0]   next_link_sync;
    logic         link_level;
    logic         next_link_level;
    logic [3:0]   idle_count;
    logic [3:0]   next_idle_count;
    logic         next_link_active;

    // Quiet cycles before the link counts as stopped; well under half a link period would false-trip
    localparam logic [3:0] LINK_IDLE_LIMIT = 4'hF;

    always_comb
    begin
        next_link_sync   = {link_sync[1:0], LINK_CLK};
        next_link_level  = link_level;
        next_idle_count  = idle_count;
        next_link_active = link_active;
        if (link_sync[1] == link_sync[2] && link_sync[2] != link_level)
        begin
            next_link_level  = link_sync[2];
            next_idle_count  = 4'h0;
            next_link_active = cfg[MODEN_BIT];
        end
        else if (idle_count != LINK_IDLE_LIMIT)
        begin
            next_idle_count = idle_count + 4'h1;
        end
        else
        begin
            next_link_active = 1'b0;
        end
        if (!cfg[MODEN_BIT] || soft_reset)
        begin
            next_link_active = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            link_sync   <= 3'h0;
            link_level  <= 1'b0;
            idle_count  <= 4'h0;
            link_active <= 1'b0;
        end
        else
        begin
            link_sync   <= next_link_sync;
            link_level  <= next_link_level;
            idle_count  <= next_idle_count;
            link_active <= next_link_active;
        end
    end

    assign LINK_ACTIVE = link_active;

    ////////////////////////////////////////////////////////////////////////////
    // Pin enables, registered; controls, combinational from the registers

    logic [1:0]   cs_oe;
    logic [3:0]   data_oe;
    logic [1:0]   next_cs_oe;
    logic [3:0]   next_data_oe;
    logic         enabled;

    assign enabled = cfg[MODEN_BIT] && !soft_reset;

    always_comb
    begin
        next_cs_oe = enabled ? cfg[CHIP_SELECT_OUTPUT_ENABLES_LSB +: 2] : 2'b00;
        next_data_oe = 4'h0;
        if (enabled)
        begin
            case (cfg[DATA_LINE_OUTPUT_ENABLE_LSB +: 2])
                DATA_LINE_OUTPUT_ENABLE_QUAD:   next_data_oe = 4'hF;
                DATA_LINE_OUTPUT_ENABLE_DUAL:   next_data_oe = 4'h3;
                DATA_LINE_OUTPUT_ENABLE_SINGLE: next_data_oe = 4'h1;
                default:       next_data_oe = 4'h0;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            cs_oe   <= 2'b00;
            data_oe <= 4'h0;
        end
        else
        begin
            cs_oe   <= next_cs_oe;
            data_oe <= next_data_oe;
        end
    end

    assign CHIP_SELECT_OE = cs_oe;
    assign DATA_LINE_OE   = data_oe;
    assign HOLD_OUT       = cfg[HOLD_BIT];
    assign WP_OUT         = cfg[WP_BIT];
    assign BURST_ENABLE   = cfg[BURST_BIT];

    // Software reset also fires every queue reset
    always_comb
    begin
        RESET_PULSES.module_reset         = soft_reset;
        RESET_PULSES.control_queue_reset  = (pend[3] || pend[0]) && pulse_count != 2'h0;
        RESET_PULSES.receive_queue_reset  = (pend[2] || pend[0]) && pulse_count != 2'h0;
        RESET_PULSES.transmit_queue_reset = (pend[1] || pend[0]) && pulse_count != 2'h0;
        DESCRIPTOR_CTRL.descriptor_start            = bdctrl[START_BIT] && enabled;
        DESCRIPTOR_CTRL.descriptor_poll_enable      = bdctrl[POLL_BIT] && enabled;
        DESCRIPTOR_CTRL.direct_memory_access_enable = bdctrl[DMA_BIT] && enabled;
    end

endmodule

// ### qsf_flash_model.sv
// Far-side flash model: clocks the link only inside a frame
`timescale 1ns/10ps
module qsf_flash_model
(
    // Frame qualifier from the controller
    input  wire logic [1:0] cs_oe,
    // Link clock toward the controller
    output logic            link_clk
);
    // Odd offset keeps the link edges off the CLK edges, at a fixed phase to CLK
    initial
    begin
        link_clk = 1'b0;
        #1.3;
        forever #40 if (|cs_oe) link_clk = ~link_clk;
    end
endmodule

// ### qsf_config_props.sv
// Checker of handshake, pulse and link timing of the configuration block
`timescale 1ns/10ps
module qsf_config_props
    import qsf_pkg::*;
(
    // Clock, reset and bus
    input wire logic                      CLK,
    input wire logic                      RESET,
    input wire logic                      CYC_I,
    input wire logic                      STB_I,
    input wire logic                      WE_I,
    input wire logic                      ACK_O,
    input wire logic                      ERR_O,
    // Watched outputs
    input wire logic                      LINK_CLK,
    input wire logic                      LINK_ACTIVE,
    input wire logic [3:0]                DATA_LINE_OE,
    input wire qsf_pkg::reset_pulses_t    RESET_PULSES,
    input wire qsf_pkg::descriptor_ctrl_t DESCRIPTOR_CTRL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic       lk_q;
    logic [4:0] idle;
    logic [4:0] next_idle;
    // Saturating cycles since the link line last moved
    always_comb
    begin
        next_idle = (LINK_CLK != lk_q) ? 5'h00 : idle + {4'h0, idle != 5'h1F};
    end
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            idle <= 5'h00;
            lk_q <= 1'b0;
        end
        else
        begin
            idle <= next_idle;
            lk_q <= LINK_CLK;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ack_lat; CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O ^ ERR_O; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("bus answer late");
    property p_ack_one; ACK_O || ERR_O |=> !ACK_O && !ERR_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("bus answer too long");
    property p_dl_code; DATA_LINE_OE inside {4'h0, 4'h1, 4'h3, 4'hF}; endproperty
    a_dl_code: assert property (p_dl_code) else $error("bad data line enables");
    property p_ctl; $rose(RESET_PULSES.control_queue_reset) |-> RESET_PULSES.control_queue_reset[*2]
        ##1 !RESET_PULSES.control_queue_reset; endproperty
    a_ctl: assert property (p_ctl) else $error("control pulse length");
    property p_rx; $rose(RESET_PULSES.receive_queue_reset) |=> RESET_PULSES.receive_queue_reset
        ##1 !RESET_PULSES.receive_queue_reset; endproperty
    a_rx: assert property (p_rx) else $error("receive pulse length");
    property p_tx; $rose(RESET_PULSES.transmit_queue_reset) |-> ##2 $fell(RESET_PULSES.transmit_queue_reset);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pulse length");
    property p_cause; $rose(|RESET_PULSES) |-> ACK_O && WE_I; endproperty
    a_cause: assert property (p_cause) else $error("pulse without write");
    property p_sw_all; $rose(RESET_PULSES.module_reset) |-> RESET_PULSES == 4'hF; endproperty
    a_sw_all: assert property (p_sw_all) else $error("soft reset misses a queue");
    property p_sw_dc; RESET_PULSES.module_reset |=> DESCRIPTOR_CTRL == 3'h0; endproperty
    a_sw_dc: assert property (p_sw_dc) else $error("descriptor kept over soft reset");
    property p_idle; idle >= 5'd24 |-> !LINK_ACTIVE; endproperty
    a_idle: assert property (p_idle) else $error("link active while idle");
    c_ack: cover property (ACK_O && WE_I);
    c_sw: cover property ($rose(RESET_PULSES.module_reset));
    c_link: cover property ($rose(LINK_ACTIVE));
endmodule
bind qsf_config qsf_config_props u_props (.CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ACK_O(ACK_O), .ERR_O(ERR_O), .LINK_CLK(LINK_CLK), .LINK_ACTIVE(LINK_ACTIVE),
    .DATA_LINE_OE(DATA_LINE_OE), .RESET_PULSES(RESET_PULSES), .DESCRIPTOR_CTRL(DESCRIPTOR_CTRL));

// ### quad_serial_flash_config_tb.sv
// Self-checking bench of the configuration block over Wishbone
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module quad_serial_flash_config_tb;
    import qsf_pkg::*;
    logic                  clk;
    logic                  reset;
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic                  re;
    logic [3:0]            adr;
    logic [3:0]            sel;
    logic [31:0]           dat;
    logic [31:0]           rq;
    logic [31:0]           base;
    wire                   lclk;
    wire                   ack;
    wire                   err;
    wire                   hold;
    wire                   wp;
    wire                   burst;
    wire                   act;
    wire  [31:0]           dout;
    wire  [1:0]            cs;
    wire  [3:0]            dl;
    wire reset_pulses_t    rp;
    wire descriptor_ctrl_t dc;
    int                    pc[4];
    int                    snap;
    int                    cyc_cnt;
    int                    error_cnt;
    int                    cmp_count;
    logic [3:0]            dl_exp[4] = '{4'h1, 4'h3, 4'hF, 4'h0};
    qsf_config DUT (.CLK(clk), .RESET(reset), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat), .DAT_O(dout), .ACK_O(ack), .ERR_O(err), .LINK_CLK(lclk),
        .LINK_ACTIVE(act), .CHIP_SELECT_OE(cs), .DATA_LINE_OE(dl), .HOLD_OUT(hold), .WP_OUT(wp),
        .BURST_ENABLE(burst), .RESET_PULSES(rp), .DESCRIPTOR_CTRL(dc));
    qsf_flash_model FLASH (.cs_oe(cs), .link_clk(lclk));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pulse cycle counts per struct bit, and the hang guard
    always @(posedge clk)
    begin
        foreach (pc[i]) if (rp[i] === 1'b1) pc[i]++;
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Classic cycle: hold until ack or err is sampled, then idle; only the bench timeout ends a wait
    task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1 && err !== 1'b1);
        rq = dout;
        re = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] a);
        xfer(a, 1'b0, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'hF;
        dat = 32'h0000_0000;
        reset = 1'b1;
        base = 32'h0080_1000;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(CFG_OFFSET);
        `CHK("cfg reset", CFG_RESET, rq)
        `CHK("pins reset", 3'b000, {hold, wp, burst})
        rd(BDCTRL_OFFSET);
        `CHK("bd reset", BDCTRL_RESET, rq)
        rd(4'hC);
        `CHK("unmapped", 1'b1, re)
        wr(CFG_OFFSET, 32'hFFFF_FFFF);
        rd(CFG_OFFSET);
        `CHK("cfg mask", CFG_RW_MASK, rq)
        `CHK("lanes rsvd", 4'h0, dl)
        `CHK("pins set", 3'b111, {hold, wp, burst})
        $display("Test map done");
        for (int i = 0; i < 4; i++)
        begin
            wr(CFG_OFFSET, base | (32'(i) << CHIP_SELECT_OUTPUT_ENABLES_LSB));
            `CHK("cs", 2'(i), cs)
            wr(CFG_OFFSET, base | (32'(i) << DATA_LINE_OUTPUT_ENABLE_LSB));
            `CHK("lanes", dl_exp[i], dl)
        end
        wr(CFG_OFFSET, 32'h0300_1000);
        `CHK("cs off", 2'b00, cs)
        $display("Test selects done");
        for (int i = 1; i < 4; i++)
        begin
            snap = pc[i];
            wr(CFG_OFFSET, base | (32'h1 << (SWRST_BIT + i)));
            rd(CFG_OFFSET);
            `CHK("pulse bit", base, rq)
            `CHK("pulse len", snap + 2, pc[i])
        end
        snap = pc[1] + pc[2] + pc[3];
        wr(CFG_OFFSET, base);
        `CHK("no pulse", snap, pc[1] + pc[2] + pc[3])
        // Pulse bits live in byte lane 2; without that lane nothing fires
        snap = pc[1];
        sel <= 4'hB;
        wr(CFG_OFFSET, base | 32'h0002_0000);
        sel <= 4'hF;
        `CHK("lane gate", snap, pc[1])
        $display("Test pulses done");
        for (int i = 0; i < 3; i++)
        begin
            wr(BDCTRL_OFFSET, 32'h1 << i);
            `CHK("desc", 3'(1 << i), dc)
        end
        wr(BDCTRL_OFFSET, 32'h0000_0007);
        wr(CFG_OFFSET, 32'h0000_1000);
        `CHK("desc off", 3'b000, dc)
        wr(CFG_OFFSET, base);
        `CHK("desc back", 3'b111, dc)
        snap = pc[0];
        wr(CFG_OFFSET, base | 32'h0001_0000);
        rd(BDCTRL_OFFSET);
        `CHK("soft bd", 32'h0000_0000, rq)
        `CHK("soft len", snap + 2, pc[0])
        rd(CFG_OFFSET);
        `CHK("soft clear", base, rq)
        $display("Test soft reset done");
        wr(CFG_OFFSET, base | 32'h0100_0000);
        for (int n = 0; n < 200 && act !== 1'b1; n++) @(posedge clk);
        rd(STATUS_OFFSET);
        `CHK("link on", 1'b1, rq[0])
        // Selects off but module on: only the idle timeout can drop the link
        wr(CFG_OFFSET, base);
        repeat (40) @(posedge clk);
        rd(STATUS_OFFSET);
        `CHK("link idle", 1'b0, rq[0])
        wr(CFG_OFFSET, base | 32'h0100_0000);
        for (int n = 0; n < 200 && act !== 1'b1; n++) @(posedge clk);
        `CHK("link again", 1'b1, act)
        wr(CFG_OFFSET, 32'h0100_1000);
        repeat (40) @(posedge clk);
        rd(STATUS_OFFSET);
        `CHK("link off", 1'b0, rq[0])
        $display("Test link done");
        test_done();
    end
endmodule
